// ==== hdl/sefe_front.sv ====
`timescale 1ns/100ps
`default_nettype none
module sefe_front #(
  parameter int WRITE_CYCLE_CYCLES = sefe_pkg::WRITE_CYCLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        chip_select_strap_low,
  input  wire logic        chip_select_strap_mid,
  input  wire logic        chip_select_strap_high,
  input  wire logic        write_protect,
  input  wire logic [7:0]  rd_data,
  output logic             rd_req,
  output logic [13:0]      word_addr,
  output logic [7:0]       wr_data,
  output logic             wr_valid,
  output logic             wr_commit,
  output logic             rd_mode,
  output logic             busy
);
  typedef struct packed {
    sefe_pkg::sefe_state_type state;
    logic                     scl_q;
    logic                     sda_q;
    logic [3:0]               bit_cnt;
    logic [7:0]               shift;
    logic [1:0]               byte_idx;
    logic                     rd_mode;
    logic                     write_pend;
    logic                     data_ack;
    logic [13:0]              addr;
    logic                     sda_oe;
    logic                     sda_out;
    logic [7:0]               wr_data;
    logic                     wr_valid;
    logic                     wr_commit;
    logic                     rd_req;
  } sefe_front_type;

  sefe_front_type st_reg;
  sefe_front_type st_next;

  logic [sefe_pkg::SYNC_W-1:0] pins_s;
  logic                        scl_s;
  logic                        sda_s;
  logic                        wp_high;
  logic [2:0]                  straps;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_det;
  logic                        stop_det;
  logic                        ctrl_match;
  logic                        byte_done;
  logic                        tmr_busy;

  sefe_sync #(
    .W (sefe_pkg::SYNC_W)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({write_protect, chip_select_strap_high,
               chip_select_strap_mid, chip_select_strap_low,
               sda_in, scl_in}),
    .q       (pins_s)
  );

  sefe_wc_timer #(
    .CYCLES (WRITE_CYCLE_CYCLES)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (st_reg.wr_commit),
    .busy    (tmr_busy)
  );

  assign scl_s = pins_s[sefe_pkg::SYNC_SCL];
  assign sda_s = pins_s[sefe_pkg::SYNC_SDA];
  // Anything but a solid high counts as low
  assign wp_high = (pins_s[sefe_pkg::SYNC_WP] === 1'b1); // [R6]
  assign straps = {pins_s[sefe_pkg::SYNC_CS_HIGH] === 1'b1,
                   pins_s[sefe_pkg::SYNC_CS_MID] === 1'b1,
                   pins_s[sefe_pkg::SYNC_CS_LOW] === 1'b1}; // [R1]

  // Edges only from synchronised copies
  assign scl_rise = scl_s & ~st_reg.scl_q; // [R26]
  assign scl_fall = ~scl_s & st_reg.scl_q; // [R26]
  // Data moving under a steady high clock
  assign start_det = scl_s & st_reg.scl_q & st_reg.sda_q & ~sda_s; // [R4] [R9]
  assign stop_det = scl_s & st_reg.scl_q & ~st_reg.sda_q & sda_s; // [R4] [R10]

  assign byte_done = scl_fall && st_reg.bit_cnt == sefe_pkg::BITS_PER_BYTE;
  assign ctrl_match = st_reg.shift[7:4] == sefe_pkg::TYPE_CODE &&
                      st_reg.shift[3:1] == straps; // [R17] [R18]

  always_comb
  begin
    st_next = st_reg;
    st_next.scl_q = scl_s;
    st_next.sda_q = sda_s;
    st_next.sda_out = 1'b0; // [R3]
    st_next.wr_valid = 1'b0;
    st_next.wr_commit = 1'b0;
    st_next.rd_req = 1'b0;
    if (stop_det)
    begin
      st_next.state = sefe_pkg::ST_IDLE; // [R10]
      st_next.sda_oe = 1'b0;
      st_next.write_pend = 1'b0;
      // Protect level taken only here
      if (st_reg.write_pend && !wp_high)
        st_next.wr_commit = 1'b1; // [R5] [R24]
    end
    else if (start_det)
    begin
      // Unfinished write is dropped on a restart
      st_next.state = sefe_pkg::ST_RECV; // [R9]
      st_next.bit_cnt = '0;
      st_next.byte_idx = sefe_pkg::BYTE_CTRL;
      st_next.sda_oe = 1'b0;
      st_next.rd_mode = 1'b0;
      st_next.write_pend = 1'b0;
      st_next.data_ack = 1'b0;
    end
    else
    begin
      case (st_reg.state)
        sefe_pkg::ST_IDLE:
        begin
          st_next.sda_oe = 1'b0;
        end
        sefe_pkg::ST_RECV:
        begin
          if (scl_rise)
          begin
            st_next.shift = {st_reg.shift[6:0], sda_s}; // [R11]
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1; // [R11]
          end
          else if (byte_done)
          begin
            st_next.state = sefe_pkg::ST_ACK;
            st_next.sda_oe = 1'b1; // [R13] [R15]
            case (st_reg.byte_idx)
              sefe_pkg::BYTE_CTRL:
              begin
                if (ctrl_match && !tmr_busy) // [R14] [R19]
                begin
                  st_next.rd_mode = st_reg.shift[0]; // [R20]
                  st_next.rd_req = st_reg.shift[0];
                  st_next.byte_idx = sefe_pkg::BYTE_ADDR_HI;
                end
                else
                begin
                  st_next.state = sefe_pkg::ST_IDLE; // [R14] [R18]
                  st_next.sda_oe = 1'b0;
                end
              end
              sefe_pkg::BYTE_ADDR_HI:
              begin
                // Top two bits are don't care
                st_next.addr[13:8] = st_reg.shift[5:0]; // [R21]
                st_next.byte_idx = sefe_pkg::BYTE_ADDR_LO;
              end
              sefe_pkg::BYTE_ADDR_LO:
              begin
                st_next.addr[7:0] = st_reg.shift; // [R21]
                st_next.byte_idx = sefe_pkg::BYTE_DATA;
              end
              default:
              begin
                // Any number of data bytes
                st_next.wr_data = st_reg.shift; // [R12]
                st_next.wr_valid = 1'b1;
                st_next.write_pend = 1'b1;
                st_next.data_ack = 1'b1;
              end
            endcase
          end
        end
        sefe_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            st_next.bit_cnt = '0;
            st_next.data_ack = 1'b0;
            if (st_reg.data_ack)
              st_next.addr[sefe_pkg::PAGE_BITS-1:0] =
                st_reg.addr[sefe_pkg::PAGE_BITS-1:0] + 6'h01;
            if (st_reg.rd_mode)
            begin
              st_next.state = sefe_pkg::ST_SEND;
              st_next.shift = rd_data;
              st_next.sda_oe = ~rd_data[7]; // [R3]
            end
            else
            begin
              st_next.state = sefe_pkg::ST_RECV;
              st_next.sda_oe = 1'b0;
            end
          end
        end
        sefe_pkg::ST_SEND:
        begin
          if (scl_fall)
          begin
            if (st_reg.bit_cnt == sefe_pkg::LAST_SEND_BIT)
            begin
              st_next.state = sefe_pkg::ST_MACK;
              st_next.sda_oe = 1'b0;
            end
            else
            begin
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.sda_oe = ~st_reg.shift[6]; // [R3]
              st_next.bit_cnt = st_reg.bit_cnt + 4'h1; // [R11]
            end
          end
        end
        sefe_pkg::ST_MACK:
        begin
          if (scl_rise)
          begin
            // Pointer advances after every byte sent
            st_next.addr = st_reg.addr + 14'h0001; // [R22]
            if (sda_s)
              st_next.state = sefe_pkg::ST_IDLE; // [R16]
            else
              st_next.rd_req = 1'b1;
          end
          else if (scl_fall)
          begin
            st_next.state = sefe_pkg::ST_SEND;
            st_next.bit_cnt = '0;
            st_next.shift = rd_data;
            st_next.sda_oe = ~rd_data[7];
          end
        end
        default:
        begin
          st_next.state = sefe_pkg::ST_IDLE;
          st_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.state <= sefe_pkg::RESET_STATE;
      st_reg.scl_q <= 1'b1;
      st_reg.sda_q <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sda_out = st_reg.sda_out;
  assign sda_oe = st_reg.sda_oe;
  assign rd_req = st_reg.rd_req;
  assign word_addr = st_reg.addr;
  assign wr_data = st_reg.wr_data;
  assign wr_valid = st_reg.wr_valid;
  assign wr_commit = st_reg.wr_commit;
  assign rd_mode = st_reg.rd_mode;
  assign busy = tmr_busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ctrl_done;
    st_reg.state == sefe_pkg::ST_RECV && byte_done &&
      st_reg.byte_idx == sefe_pkg::BYTE_CTRL;
  endsequence

  sequence s_ctrl_ok;
    ctrl_match && !tmr_busy;
  endsequence

  a_never_high: assert property (sda_out == 1'b0) // [R3]
    else $error("data line driven high");

  a_start_resync: assert property (start_det |=>
    st_reg.state == sefe_pkg::ST_RECV && st_reg.bit_cnt == '0) // [R9]
    else $error("start did not resync framing");

  a_stop_idle: assert property (stop_det |=>
    st_reg.state == sefe_pkg::ST_IDLE && !sda_oe) // [R10]
    else $error("stop did not idle the slave");

  a_ctrl_ack: assert property (s_ctrl_done ##0 s_ctrl_ok |=>
    sda_oe && st_reg.state == sefe_pkg::ST_ACK) // [R19]
    else $error("matching control byte not acknowledged");

  a_busy_noack: assert property (s_ctrl_done ##0 tmr_busy |=>
    !sda_oe [*2]) // [R14]
    else $error("acknowledge given while busy");

  a_wp_inhibit: assert property (stop_det && wp_high |=>
    !wr_commit) // [R5]
    else $error("write committed while protected");

  a_commit_busy: assert property (wr_commit |=> busy [*8]) // [R25]
    else $error("commit did not start write cycle");

  a_nack_release: assert property (st_reg.state == sefe_pkg::ST_MACK &&
    scl_rise && sda_s && !stop_det && !start_det |=>
    st_reg.state == sefe_pkg::ST_IDLE && !sda_oe) // [R16]
    else $error("line not released after master nack");

  a_one_bit: assert property (st_reg.state == sefe_pkg::ST_RECV &&
    scl_rise && !start_det && !stop_det |=>
    st_reg.bit_cnt == $past(st_reg.bit_cnt) + 4'h1) // [R11]
    else $error("bit count not advanced by one");

  a_ack_hold: assert property (st_reg.state == sefe_pkg::ST_ACK &&
    scl_rise |-> sda_oe) // [R15]
    else $error("acknowledge not held under clock high");
endmodule
`default_nettype wire

// ==== pkg/sefe_pkg.sv ====
// Summary of operation
// R1 - Floating chip-select strap reads as low
// R2 - Master settles straps before bus traffic
// R3 - Data line only pulled low or released
// R4 - Data changes only while clock low
// R5 - Write-protect high inhibits writes, reads continue
// R6 - Floating write-protect means unprotected
// R7 - Master alone drives clock and conditions
// R8 - Master starts only on idle bus
// R9 - Falling data, clock high: start, resync
// R10 - Rising data, clock high: stop
// R11 - One bit per clock pulse
// R12 - No fixed byte count per transaction
// R13 - Addressed receiver acknowledges every byte
// R14 - No acknowledge during programming cycle
// R15 - Acknowledge held low through clock high
// R16 - Master nack on last read; release line
// R17 - First byte: type 1010, selects, direction
// R18 - Respond only when selects match straps
// R19 - Full match: acknowledge, choose direction
// R20 - Direction bit one reads, zero writes
// R21 - Two address bytes, high first, 14 bits
// R22 - Read pointer wraps inside own space
// R23 - Reduced-pin master sends low selects zero
// R24 - Write-protect sampled at closing stop
// R25 - Write cycle at most 5 ms, no acks
// R26 - Synchronise clock and data, then edges
`default_nettype none
package sefe_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int WRITE_CYCLE_MS = 5;
  // Longest time: rounds down
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * (CLK_HZ / 1000);
  localparam int ADDR_W = 14;
  localparam int PAGE_BITS = 6;
  localparam logic [3:0] TYPE_CODE = 4'ha;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_SEND_BIT = 4'h7;
  localparam logic [1:0] BYTE_CTRL = 2'h0;
  localparam logic [1:0] BYTE_ADDR_HI = 2'h1;
  localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;
  localparam int SYNC_W = 6;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_CS_LOW = 2;
  localparam int SYNC_CS_MID = 3;
  localparam int SYNC_CS_HIGH = 4;
  localparam int SYNC_WP = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h03;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK  = 5'h04,
    ST_SEND = 5'h08,
    ST_MACK = 5'h10
  } sefe_state_type;
  localparam sefe_state_type RESET_STATE = ST_IDLE;
endpackage
`default_nettype wire

// ==== hdl/sefe_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module sefe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sefe_sync_type;
  sefe_sync_type s_reg;
  sefe_sync_type s_next;

  // First stage feeds only the second
  always_comb
  begin
    s_next.meta = d; // [R26]
    s_next.q = s_reg.meta; // [R26]
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_reg.meta <= sefe_pkg::SYNC_RESET[W-1:0];
      s_reg.q <= sefe_pkg::SYNC_RESET[W-1:0];
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;
endmodule
`default_nettype wire

// ==== hdl/sefe_wc_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module sefe_wc_timer #(
  parameter int CYCLES = sefe_pkg::WRITE_CYCLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);
  typedef struct packed {
    logic          busy;
    logic [CW-1:0] cnt;
  } sefe_tmr_type;
  sefe_tmr_type t_reg;
  sefe_tmr_type t_next;

  always_comb
  begin
    t_next = t_reg;
    if (start)
    begin
      t_next.busy = 1'b1; // [R25]
      t_next.cnt = CW'(CYCLES - 1);
    end
    else if (t_reg.busy)
    begin
      if (t_reg.cnt == '0)
        t_next.busy = 1'b0; // [R25]
      else
        t_next.cnt = t_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign busy = t_reg.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_busy_ends: assert property ($fell(t_reg.busy) |-> $past(t_reg.cnt) == '0) // [R25]
    else $error("write cycle ended early");
endmodule
`default_nettype wire

// ==== verification/sefe_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sefe_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam time Q = 200;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Works from idle and as a repeated start
  task automatic start_c();
    begin
      sda_low = 1'b0;
      #Q;
      scl = 1'b1;
      #Q;
      sda_low = 1'b1;
      #Q;
      scl = 1'b0;
      #Q;
    end
  endtask
  task automatic stop_c();
    begin
      sda_low = 1'b1;
      #Q;
      scl = 1'b1;
      #Q;
      sda_low = 1'b0;
      #Q;
    end
  endtask
  task automatic clk_bit(input logic b, output logic s);
    begin
      sda_low = ~b;
      #Q;
      scl = 1'b1;
      #Q;
      s = sda;
      #Q;
      scl = 1'b0;
      #Q;
    end
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
        clk_bit(d[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
    end
  endtask
  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic s;
    begin
      for (int i = 7; i >= 0; i--)
      begin
        clk_bit(1'b1, s);
        d[i] = s;
      end
      clk_bit(~mack, s);
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        sys_rst;
  logic [2:0]  strap;
  logic        wp;
  logic        scl;
  logic        m_low;
  wire         sda;
  logic        sda_out;
  logic        sda_oe;
  logic [7:0]  rd_data;
  logic        rd_req;
  logic [13:0] word_addr;
  logic [7:0]  wr_data;
  logic        wr_valid;
  logic        wr_commit;
  logic        rd_mode;
  logic        busy;
  logic        a;
  logic [7:0]  d;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          n_commit = 0;
  int          busy_cnt = 0;
  int          n_rdreq = 0;
  int          i_wait;
  logic [13:0] wa_q[$];
  logic [7:0]  wd_q[$];
  // Pull-up on the wire; either party may pull low
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  // Array stand-in, pure function of the pointer
  assign rd_data = word_addr[7:0] ^ {2'h0, word_addr[13:8]};
  sefe_front #(.WRITE_CYCLE_CYCLES(200)) sefe_front_i (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_strap_low(strap[0]), .chip_select_strap_mid(strap[1]),
    .chip_select_strap_high(strap[2]), .write_protect(wp),
    .rd_data(rd_data), .rd_req(rd_req), .word_addr(word_addr),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_commit(wr_commit),
    .rd_mode(rd_mode), .busy(busy));
  sefe_master_model sefe_master_model_i (
    .scl(scl), .sda_low(m_low), .sda(sda));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (wr_valid === 1'b1)
    begin
      wa_q.push_back(word_addr);
      wd_q.push_back(wr_data);
    end
    if (wr_commit === 1'b1)
      n_commit++;
    if (busy === 1'b1)
      busy_cnt++;
    if (rd_req === 1'b1)
      n_rdreq++;
    if (sda_oe === 1'b1 && sda_out !== 1'b0)
    begin
      $display("wrong value at %0t: line driven high", $time);
      bad_count++;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        $display("wrong value at %0t: %s", $time, msg);
        bad_count++;
      end
    end
  endtask
  // Pins move and outputs are read clear of the edge
  task automatic step(input int n);
    begin
      repeat (n) @(posedge clk);
      #10;
    end
  endtask
  // Unset straps float, relying on the strap compare to read z as low
  task automatic set_pins(input logic [2:0] s, input logic w);
    begin
      @(posedge clk);
      #10;
      for (int i = 0; i < 3; i++)
        strap[i] = s[i] ? 1'b1 : 1'bz;
      wp = w ? 1'b1 : 1'bz;
    end
  endtask
  task automatic ctrl(input logic [7:0] b, input logic exp);
    begin
      sefe_master_model_i.start_c();
      sefe_master_model_i.send_byte(b, a);
      chk(a, exp, "control ack");
    end
  endtask
  task automatic wr_bytes(input logic [23:0] v);
    begin
      for (int i = 2; i >= 0; i--)
      begin
        sefe_master_model_i.send_byte(v[i*8 +: 8], a);
        chk(a, 1'b1, "byte ack");
      end
    end
  endtask
  task automatic wrap_up();
    begin
      $display("mismatches %0d of %0d compares", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    #3ms;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    sys_rst = 1'b1;
    strap = 3'h0;
    wp = 1'b0;
    repeat (8) @(posedge clk);
    #10;
    sys_rst = 1'b0;
    step(4);
    chk({sda_oe, busy, rd_mode}, 3'h0, "reset outputs");
    chk(word_addr, 14'h0, "reset pointer");
    for (int s = 0; s < 8; s++)
    begin
      set_pins(s[2:0], 1'b0);
      ctrl({4'ha, s[2:0], 1'b1}, 1'b1);
      chk(rd_mode, 1'b1, "read mode");
      sefe_master_model_i.recv_byte(1'b0, d);
      sefe_master_model_i.stop_c();
      ctrl({4'ha, ~s[2:0], 1'b1}, 1'b0);
      sefe_master_model_i.stop_c();
    end
    $display("test straps done");
    set_pins(3'h5, 1'b0);
    ctrl(8'haa, 1'b1);
    wr_bytes(24'hc13f11);
    wr_bytes(24'h223344);
    sefe_master_model_i.stop_c();
    step(4);
    chk(busy, 1'b1, "busy after stop");
    chk(n_commit, 1, "commit count");
    chk(wa_q.size(), 4, "data byte count");
    chk(wa_q[0], 14'h013f, "first address");
    chk(wd_q[0], 8'h11, "first data");
    chk(wa_q[1], 14'h0100, "page wrap address");
    chk(wd_q[3], 8'h44, "last data");
    ctrl(8'haa, 1'b0);
    sefe_master_model_i.stop_c();
    i_wait = 0;
    while (busy !== 1'b0 && i_wait < 400)
    begin
      step(1);
      i_wait++;
    end
    if (busy !== 1'b0)
    begin
      $display("wrong value at %0t: write cycle hung", $time);
      bad_count++;
      wrap_up();
    end
    chk(busy_cnt, 200, "write cycle length");
    $display("test write done");
    ctrl(8'hba, 1'b0);
    sefe_master_model_i.stop_c();
    set_pins(3'h5, 1'b1);
    ctrl(8'haa, 1'b1);
    wr_bytes(24'h001033);
    sefe_master_model_i.stop_c();
    set_pins(3'h5, 1'b0);
    step(20);
    chk(n_commit, 1, "protected commit");
    chk(busy_cnt, 200, "protected busy");
    $display("test protect done");
    ctrl(8'haa, 1'b1);
    // Data byte bumps the low six bits: pointer ends on 3fff
    wr_bytes(24'hfffeab);
    ctrl(8'hab, 1'b1);
    sefe_master_model_i.recv_byte(1'b1, d);
    chk(d, 8'hc0, "read top byte");
    sefe_master_model_i.recv_byte(1'b0, d);
    chk(d, 8'h00, "read wrapped byte");
    sefe_master_model_i.stop_c();
    step(4);
    chk(sda_oe, 1'b0, "released after nack");
    chk(n_commit, 1, "restart drops commit");
    chk(word_addr, 14'h0001, "pointer after read");
    chk(n_rdreq, 10, "read requests");
    $display("test read done");
    wrap_up();
  end
endmodule
`default_nettype wire
